// File: core/dcc_pkg.sv
package dcc_pkg;
   // ----------------------------------------------------------------
   // geometry and offsets
   // ----------------------------------------------------------------
   localparam int             NUM_CH        = 7;
   localparam int             ADDR_W        = 8;
   localparam logic [7:0]     OFS_FLAG      = 8'h00;
   localparam logic [7:0]     OFS_CLEAR     = 8'h04;
   localparam logic [7:0]     OFS_CTL_BASE  = 8'h08;
   localparam logic [7:0]     OFS_CTL_STEP  = 8'h14;
   localparam logic [3:0]     NO_CHANNEL    = 4'hf;

   // ----------------------------------------------------------------
   // flag and clear layout, four bits per channel
   // ----------------------------------------------------------------
   localparam int             FLG_STRIDE    = 4;
   localparam int             FLG_SUM       = 0;
   localparam int             FLG_ALL       = 1;
   localparam int             FLG_HALF      = 2;
   localparam int             FLG_FAULT     = 3;
   localparam int             FLG_W         = 28;
   localparam logic [27:0]    FLAG_RESET    = 28'h0000000;

   // ----------------------------------------------------------------
   // channel control layout
   // ----------------------------------------------------------------
   localparam int             CTL_ON        = 0;
   localparam int             CTL_ALL_IE    = 1;
   localparam int             CTL_HALF_IE   = 2;
   localparam int             CTL_FAULT_IE  = 3;
   localparam int             CTL_DIR       = 4;
   localparam int             CTL_WRAP      = 5;
   localparam int             CTL_PSTEP     = 6;
   localparam int             CTL_MSTEP     = 7;
   localparam int             CTL_PSIZE     = 8;
   localparam int             CTL_MSIZE     = 10;
   localparam int             CTL_RANK      = 12;
   localparam int             CTL_COPY      = 14;
   localparam logic [31:0]    CTL_IMPL_MASK = 32'h00007fff;
   localparam logic [31:0]    CTL_LOCK_MASK = 32'h00007ff0;
   localparam logic [31:0]    CTL_RESET     = 32'h00000000;

   typedef enum logic [1:0] {
      RANK_LOW     = 2'b00,
      RANK_MEDIUM  = 2'b01,
      RANK_HIGH    = 2'b10,
      RANK_HIGHEST = 2'b11
   } dcc_rank_t;

   typedef enum logic [1:0] {
      SIZE_8   = 2'b00,
      SIZE_16  = 2'b01,
      SIZE_32  = 2'b10,
      SIZE_RSV = 2'b11
   } dcc_size_t;
endpackage : dcc_pkg

// File: core/dcc_regs.sv
`timescale 1ns/10ps
module dcc_regs
   import dcc_pkg::*;
(
   input  wire logic               ref_clk,
   input  wire logic               nrst,
   input  wire logic [ADDR_W-1:0]  bus_addr,
   input  wire logic [31:0]        bus_wdata,
   input  wire logic               bus_wr,
   input  wire logic               bus_rd,
   output logic      [31:0]        bus_rdata,
   input  wire logic [NUM_CH-1:0]  ev_fault,
   input  wire logic [NUM_CH-1:0]  ev_half_done,
   input  wire logic [NUM_CH-1:0]  ev_all_done,
   input  wire logic [NUM_CH-1:0]  xfer_req,
   output logic      [NUM_CH-1:0]  xfer_grant,
   output logic      [NUM_CH-1:0]  chan_irq,
   output logic      [NUM_CH-1:0]  channel_on,
   output logic      [NUM_CH-1:0]  mem_copy_mode,
   output logic      [13:0]        channel_rank,
   output logic      [13:0]        memory_word_size,
   output logic      [13:0]        periph_word_size,
   output logic      [NUM_CH-1:0]  memory_addr_step,
   output logic      [NUM_CH-1:0]  periph_addr_step,
   output logic      [NUM_CH-1:0]  wraparound_on,
   output logic      [NUM_CH-1:0]  mem_to_periph
);

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   function automatic logic [3:0] ctl_index(input logic [ADDR_W-1:0] a);
      ctl_index = NO_CHANNEL;
      for (int i = 0; i < NUM_CH; i++) begin
         if (a == 8'(OFS_CTL_BASE + OFS_CTL_STEP * i)) begin
            ctl_index = 4'(i);
         end
      end
   endfunction : ctl_index

   logic [NUM_CH-1:0][31:0] ctl_ff;
   logic [NUM_CH-1:0][31:0] nxt_ctl;
   logic [FLG_W-1:0]        flag_ff;
   logic [FLG_W-1:0]        nxt_flag;
   logic [31:0]             rdata_ff;
   logic [31:0]             nxt_rdata;
   logic [NUM_CH-1:0]       irq_ff;
   logic [NUM_CH-1:0]       grant_ff;
   logic [NUM_CH-1:0]       nxt_grant;
   logic [3:0]              wr_idx;
   logic [3:0]              rd_idx;
   logic                    clr_wr;

   assign wr_idx = bus_wr ? ctl_index(bus_addr) : NO_CHANNEL;
   assign rd_idx = ctl_index(bus_addr);
   assign clr_wr = bus_wr && (bus_addr == OFS_CLEAR);

   // ----------------------------------------------------------------
   // channel control registers
   // ----------------------------------------------------------------
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         if (ctl_ff[c][CTL_ON]) begin
            // mode, rank and sizes hold while running
            nxt_ctl[c] = (ctl_ff[c] & CTL_LOCK_MASK)
                       | (bus_wdata & CTL_IMPL_MASK & ~CTL_LOCK_MASK);
         end else begin
            nxt_ctl[c] = bus_wdata & CTL_IMPL_MASK;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      for (int c = 0; c < NUM_CH; c++) begin
         if (!nrst) begin
            ctl_ff[c] <= CTL_RESET;
         end else if (wr_idx == 4'(c)) begin
            ctl_ff[c] <= nxt_ctl[c];
         end
      end
   end

   // ----------------------------------------------------------------
   // field outputs
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NUM_CH; g++) begin : g_fields
      assign channel_on[g]             = ctl_ff[g][CTL_ON];
      assign mem_copy_mode[g]          = ctl_ff[g][CTL_COPY];
      assign channel_rank[2*g +: 2]    = ctl_ff[g][CTL_RANK +: 2];
      assign memory_word_size[2*g +: 2] = ctl_ff[g][CTL_MSIZE +: 2];
      assign periph_word_size[2*g +: 2] = ctl_ff[g][CTL_PSIZE +: 2];
      assign memory_addr_step[g]       = ctl_ff[g][CTL_MSTEP];
      assign periph_addr_step[g]       = ctl_ff[g][CTL_PSTEP];
      assign wraparound_on[g]          = ctl_ff[g][CTL_WRAP];
      assign mem_to_periph[g]          = ctl_ff[g][CTL_DIR];
   end

   // ----------------------------------------------------------------
   // event flags, set wins over clear
   // ----------------------------------------------------------------
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         logic sum_clr;
         sum_clr = clr_wr && bus_wdata[FLG_STRIDE*c + FLG_SUM];
         nxt_flag[FLG_STRIDE*c + FLG_FAULT] = ev_fault[c]
            || (flag_ff[FLG_STRIDE*c + FLG_FAULT]
                && !(sum_clr || (clr_wr && bus_wdata[FLG_STRIDE*c + FLG_FAULT])));
         nxt_flag[FLG_STRIDE*c + FLG_HALF] = ev_half_done[c]
            || (flag_ff[FLG_STRIDE*c + FLG_HALF]
                && !(sum_clr || (clr_wr && bus_wdata[FLG_STRIDE*c + FLG_HALF])));
         nxt_flag[FLG_STRIDE*c + FLG_ALL] = ev_all_done[c]
            || (flag_ff[FLG_STRIDE*c + FLG_ALL]
                && !(sum_clr || (clr_wr && bus_wdata[FLG_STRIDE*c + FLG_ALL])));
         nxt_flag[FLG_STRIDE*c + FLG_SUM] = ev_fault[c] || ev_half_done[c]
            || ev_all_done[c]
            || (flag_ff[FLG_STRIDE*c + FLG_SUM] && !sum_clr);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         flag_ff <= FLAG_RESET;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   // ----------------------------------------------------------------
   // per-channel interrupt
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      for (int c = 0; c < NUM_CH; c++) begin
         if (!nrst) begin
            irq_ff[c] <= 1'b0;
         end else begin
            irq_ff[c] <= (flag_ff[FLG_STRIDE*c + FLG_FAULT] && ctl_ff[c][CTL_FAULT_IE])
               || (flag_ff[FLG_STRIDE*c + FLG_HALF] && ctl_ff[c][CTL_HALF_IE])
               || (flag_ff[FLG_STRIDE*c + FLG_ALL] && ctl_ff[c][CTL_ALL_IE]);
         end
      end
   end

   assign chan_irq = irq_ff;

   // ----------------------------------------------------------------
   // request arbiter
   // ----------------------------------------------------------------
   always_comb begin
      logic       found;
      logic [1:0] best;
      found     = 1'b0;
      best      = RANK_LOW;
      nxt_grant = '0;
      for (int c = 0; c < NUM_CH; c++) begin
         // strict compare keeps the lower channel on a tie
         if (xfer_req[c] && ctl_ff[c][CTL_ON]
             && (!found || ctl_ff[c][CTL_RANK +: 2] > best)) begin
            found     = 1'b1;
            best      = ctl_ff[c][CTL_RANK +: 2];
            nxt_grant = '0;
            nxt_grant[c] = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         grant_ff <= '0;
      end else begin
         grant_ff <= nxt_grant;
      end
   end

   assign xfer_grant = grant_ff;

   // ----------------------------------------------------------------
   // read port, data valid only in the cycle after the strobe
   // ----------------------------------------------------------------
   always_comb begin
      nxt_rdata = 32'h00000000;
      if (!bus_rd) begin
         nxt_rdata = 32'h00000000;
      end else if (bus_addr == OFS_FLAG) begin
         nxt_rdata = {4'h0, flag_ff};
      end else if (bus_addr == OFS_CLEAR) begin
         nxt_rdata = 32'h00000000;
      end else if (rd_idx != NO_CHANNEL) begin
         nxt_rdata = ctl_ff[rd_idx[2:0]];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rdata_ff <= 32'h00000000;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign bus_rdata = rdata_ff;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   property p_fault_clr;
      clr_wr && bus_wdata[FLG_FAULT] && !ev_fault[0] |=> !flag_ff[FLG_FAULT];
   endproperty
   a_fault_clr: assert property (p_fault_clr) else $error("fault flag not cleared");

   property p_zero_keeps;
      clr_wr && !bus_wdata[FLG_FAULT] && !bus_wdata[FLG_SUM] && flag_ff[FLG_FAULT]
         |=> flag_ff[FLG_FAULT];
   endproperty
   a_zero_keeps: assert property (p_zero_keeps) else $error("zero clear bit lost a flag");

   property p_half_clr;
      clr_wr && bus_wdata[FLG_STRIDE + FLG_HALF] && !ev_half_done[1]
         |=> !flag_ff[FLG_STRIDE + FLG_HALF];
   endproperty
   a_half_clr: assert property (p_half_clr) else $error("half-done flag not cleared");

   property p_all_clr;
      clr_wr && bus_wdata[2*FLG_STRIDE + FLG_ALL] && !ev_all_done[2]
         |=> !flag_ff[2*FLG_STRIDE + FLG_ALL];
   endproperty
   a_all_clr: assert property (p_all_clr) else $error("all-done flag not cleared");

   property p_sum_clr;
      clr_wr && bus_wdata[6*FLG_STRIDE + FLG_SUM]
         && !ev_fault[6] && !ev_half_done[6] && !ev_all_done[6]
         |=> flag_ff[6*FLG_STRIDE +: FLG_STRIDE] == 4'h0;
   endproperty
   a_sum_clr: assert property (p_sum_clr) else $error("summary clear left a flag");

   property p_sum_set;
      ev_half_done[4] |=> flag_ff[4*FLG_STRIDE + FLG_SUM] && flag_ff[4*FLG_STRIDE + FLG_HALF];
   endproperty
   a_sum_set: assert property (p_sum_set) else $error("summary flag not set");

   property p_ctl_store;
      bus_wr && ctl_index(bus_addr) == 4'd3 && !ctl_ff[3][CTL_ON]
         |=> ctl_ff[3] == ($past(bus_wdata) & CTL_IMPL_MASK);
   endproperty
   a_ctl_store: assert property (p_ctl_store) else $error("control write not stored");

   property p_lock;
      bus_wr && ctl_index(bus_addr) == 4'd0 && ctl_ff[0][CTL_ON]
         |=> ctl_ff[0][14:4] == $past(ctl_ff[0][14:4])
             && ctl_ff[0][3:1] == $past(bus_wdata[3:1]);
   endproperty
   a_lock: assert property (p_lock) else $error("locked field changed while on");

   property p_irq;
      flag_ff[FLG_FAULT] && ctl_ff[0][CTL_FAULT_IE] |=> chan_irq[0];
   endproperty
   a_irq: assert property (p_irq) else $error("enabled fault gave no interrupt");

   property p_irq_off;
      !(flag_ff[FLG_HALF] && ctl_ff[0][CTL_HALF_IE])
         && !(flag_ff[FLG_ALL] && ctl_ff[0][CTL_ALL_IE])
         && !(flag_ff[FLG_FAULT] && ctl_ff[0][CTL_FAULT_IE]) |=> !chan_irq[0];
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("masked flag raised interrupt");

   property p_tie;
      xfer_req == 7'h22 && channel_on[1] && channel_on[5]
         && channel_rank[3:2] == channel_rank[11:10] |=> xfer_grant == 7'h02;
   endproperty
   a_tie: assert property (p_tie) else $error("tie not given to lower channel");

   property p_rsv;
      bus_rd && rd_idx != NO_CHANNEL |=> bus_rdata[31:15] == 17'h00000;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved control bits read nonzero");

   // ----------------------------------------------------------------
   // per-channel flag checks
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NUM_CH; g++) begin : g_flag_chk
      property p_fault_clr_ch;
         clr_wr && bus_wdata[FLG_STRIDE*g + FLG_FAULT] && !ev_fault[g]
            |=> !flag_ff[FLG_STRIDE*g + FLG_FAULT];
      endproperty
      a_fault_clr_ch: assert property (p_fault_clr_ch) else $error("fault flag kept");

      property p_half_clr_ch;
         clr_wr && bus_wdata[FLG_STRIDE*g + FLG_HALF] && !ev_half_done[g]
            |=> !flag_ff[FLG_STRIDE*g + FLG_HALF];
      endproperty
      a_half_clr_ch: assert property (p_half_clr_ch) else $error("half-done flag kept");

      property p_all_clr_ch;
         clr_wr && bus_wdata[FLG_STRIDE*g + FLG_ALL] && !ev_all_done[g]
            |=> !flag_ff[FLG_STRIDE*g + FLG_ALL];
      endproperty
      a_all_clr_ch: assert property (p_all_clr_ch) else $error("all-done flag kept");

      property p_sum_clr_ch;
         clr_wr && bus_wdata[FLG_STRIDE*g + FLG_SUM]
            && !ev_fault[g] && !ev_half_done[g] && !ev_all_done[g]
            |=> flag_ff[FLG_STRIDE*g +: FLG_STRIDE] == 4'h0;
      endproperty
      a_sum_clr_ch: assert property (p_sum_clr_ch) else $error("summary clear incomplete");

      property p_zero_keeps_ch;
         clr_wr && bus_wdata[FLG_STRIDE*g +: FLG_STRIDE] == 4'h0
            |=> (~flag_ff[FLG_STRIDE*g +: FLG_STRIDE]
                 & $past(flag_ff[FLG_STRIDE*g +: FLG_STRIDE])) == 4'h0;
      endproperty
      a_zero_keeps_ch: assert property (p_zero_keeps_ch) else $error("flag lost");

      property p_set_ch;
         ev_fault[g] || ev_half_done[g] || ev_all_done[g]
            |=> flag_ff[FLG_STRIDE*g + FLG_SUM];
      endproperty
      a_set_ch: assert property (p_set_ch) else $error("summary flag missed an event");

      property p_hw_only_ch;
         !ev_fault[g] |=> !$rose(flag_ff[FLG_STRIDE*g + FLG_FAULT]);
      endproperty
      a_hw_only_ch: assert property (p_hw_only_ch) else $error("fault flag rose alone");
   end

   // ----------------------------------------------------------------
   // per-channel control checks
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NUM_CH; g++) begin : g_ctl_chk
      property p_lock_ch;
         wr_idx == 4'(g) && ctl_ff[g][CTL_ON]
            |=> ctl_ff[g][CTL_COPY:CTL_DIR] == $past(ctl_ff[g][CTL_COPY:CTL_DIR]);
      endproperty
      a_lock_ch: assert property (p_lock_ch) else $error("locked field changed");

      property p_enables_ch;
         wr_idx == 4'(g) |=> ctl_ff[g][CTL_FAULT_IE:CTL_ON] == $past(bus_wdata[3:0]);
      endproperty
      a_enables_ch: assert property (p_enables_ch) else $error("enable bits not written");

      property p_refuse_ch;
         !(xfer_req[g] && ctl_ff[g][CTL_ON]) |=> !xfer_grant[g];
      endproperty
      a_refuse_ch: assert property (p_refuse_ch) else $error("grant to idle channel");
   end

   property p_onehot;
      $onehot0(xfer_grant);
   endproperty
   a_onehot: assert property (p_onehot) else $error("more than one grant");

   c_clear: cover property (clr_wr ##1 flag_ff == FLAG_RESET);
   c_locked: cover property (bus_wr && wr_idx == 4'd0 && ctl_ff[0][CTL_ON]);
   c_grant: cover property ($countones(xfer_req & channel_on) > 1 ##1 xfer_grant != '0);
   c_irq: cover property (chan_irq != '0);
   c_set_wins: cover property (clr_wr && bus_wdata[FLG_FAULT] && ev_fault[0]);
endmodule : dcc_regs

// File: dv/tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb
   import dcc_pkg::*;
;
   // -----------------------------------------
   // stimulus, model and design
   // -----------------------------------------
   logic              ref_clk, nrst, bus_wr, bus_rd;
   logic [ADDR_W-1:0] bus_addr;
   logic [31:0]       bus_wdata, bus_rdata, d;
   logic [NUM_CH-1:0] ev_fault, ev_half_done, ev_all_done, xfer_req, xfer_grant, chan_irq;
   logic [NUM_CH-1:0] channel_on, mem_copy_mode, memory_addr_step, periph_addr_step;
   logic [NUM_CH-1:0] wraparound_on, mem_to_periph;
   logic [13:0]       channel_rank, memory_word_size, periph_word_size;
   logic [31:0]       ctl_m [NUM_CH];
   logic [27:0]       flg_m;
   integer            seed = 84;
   integer            n_fail = 0;
   integer            n_compared = 0;

   dcc_regs uut (.ref_clk(ref_clk), .nrst(nrst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ev_fault(ev_fault),
      .ev_half_done(ev_half_done), .ev_all_done(ev_all_done), .xfer_req(xfer_req),
      .xfer_grant(xfer_grant), .chan_irq(chan_irq), .channel_on(channel_on),
      .mem_copy_mode(mem_copy_mode), .channel_rank(channel_rank),
      .memory_word_size(memory_word_size), .periph_word_size(periph_word_size),
      .memory_addr_step(memory_addr_step), .periph_addr_step(periph_addr_step),
      .wraparound_on(wraparound_on), .mem_to_periph(mem_to_periph));

   always #20 ref_clk = ~ref_clk;

   // -----------------------------------------
   // expectation helpers
   // -----------------------------------------
   function automatic logic [7:0] ca(input int c);
      ca = 8'(OFS_CTL_BASE + OFS_CTL_STEP * c);
   endfunction : ca

   // highest rank first, ties to the lower channel
   function automatic logic [NUM_CH-1:0] exp_grant(input logic [NUM_CH-1:0] r);
      int         b;
      logic [1:0] br;
      b = -1;
      br = 2'b00;
      exp_grant = '0;
      for (int c = 0; c < NUM_CH; c++) begin
         if (r[c] && ctl_m[c][CTL_ON] && (b < 0 || ctl_m[c][CTL_RANK+:2] > br)) begin
            b = c;
            br = ctl_m[c][CTL_RANK+:2];
         end
      end
      if (b >= 0) exp_grant[b] = 1'b1;
   endfunction : exp_grant

   function automatic logic [NUM_CH-1:0] exp_irq();
      for (int c = 0; c < NUM_CH; c++) exp_irq[c] = |(flg_m[4*c+1+:3] & ctl_m[c][3:1]);
   endfunction : exp_irq

   // -----------------------------------------
   // bus and event tasks
   // -----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      bus_addr <= a;
      bus_wdata <= v;
      bus_wr <= 1'b1;
      @(posedge ref_clk);
      bus_wr <= 1'b0;
      for (int c = 0; c < NUM_CH; c++) begin
         if (a == ca(c)) ctl_m[c] = ctl_m[c][CTL_ON] ?
            (ctl_m[c] & CTL_LOCK_MASK) | (v & 32'h0000000f) : v & CTL_IMPL_MASK;
         if (a == OFS_CLEAR) flg_m[4*c+:4] &= v[4*c] ? 4'h0 : ~v[4*c+:4];
      end
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge ref_clk);
      bus_rd <= 1'b0;
      #1 `CHK(bus_rdata, e)
   endtask : rd

   task automatic ev(input logic [NUM_CH-1:0] f, input logic [NUM_CH-1:0] h,
                     input logic [NUM_CH-1:0] a);
      @(posedge ref_clk);
      ev_fault <= f;
      ev_half_done <= h;
      ev_all_done <= a;
      @(posedge ref_clk);
      ev_fault <= '0;
      ev_half_done <= '0;
      ev_all_done <= '0;
      for (int c = 0; c < NUM_CH; c++)
         flg_m[4*c+:4] |= {f[c], h[c], a[c], f[c] | h[c] | a[c]};
   endtask : ev

   task automatic chk_ports();
      for (int c = 0; c < NUM_CH; c++) begin
         `CHK(channel_on[c], ctl_m[c][CTL_ON])
         `CHK(mem_copy_mode[c], ctl_m[c][CTL_COPY])
         `CHK(channel_rank[2*c+:2], ctl_m[c][CTL_RANK+:2])
         `CHK(memory_word_size[2*c+:2], ctl_m[c][CTL_MSIZE+:2])
         `CHK(periph_word_size[2*c+:2], ctl_m[c][CTL_PSIZE+:2])
         `CHK(memory_addr_step[c], ctl_m[c][CTL_MSTEP])
         `CHK(periph_addr_step[c], ctl_m[c][CTL_PSTEP])
         `CHK(wraparound_on[c], ctl_m[c][CTL_WRAP])
         `CHK(mem_to_periph[c], ctl_m[c][CTL_DIR])
      end
   endtask : chk_ports

   task conclude;
      if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude

   // -----------------------------------------
   // main sequence
   // -----------------------------------------
   initial begin
      ref_clk = 1'b0;
      nrst = 1'b0;
      {bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
      {ev_fault, ev_half_done, ev_all_done, xfer_req} = '0;
      flg_m = '0;
      foreach (ctl_m[c]) ctl_m[c] = CTL_RESET;
      repeat (10) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      chk_ports();
      rd(OFS_FLAG, 32'h0);
      rd(OFS_CLEAR, 32'h0);
      for (int c = 0; c < NUM_CH; c++) rd(ca(c), 32'h0);
      // random configs after round 0 (32'hfffffffe, bit 0 clear); bit 0 random so locked writes occur
      for (int r = 0; r < 8; r++) begin
         for (int c = 0; c < NUM_CH; c++) begin
            d = (r == 0) ? 32'hfffffffe : $random(seed);
            wr(ca(c), d);
            rd(ca(c), ctl_m[c]);
         end
         chk_ports();
         wr(8'h0c, $random(seed));
         rd(8'h0c, 32'h0);
         for (int k = 0; k < 10; k++) begin
            @(posedge ref_clk);
            xfer_req <= NUM_CH'($random(seed));
            @(posedge ref_clk);
            #1 `CHK(xfer_grant, exp_grant(xfer_req))
         end
      end
      // tie between channels 1 and 5 at equal rank
      for (int c = 1; c < NUM_CH; c += 4) begin
         wr(ca(c), 32'h00000000);
         wr(ca(c), 32'h00002001);
      end
      @(posedge ref_clk);
      xfer_req <= 7'h22;
      @(posedge ref_clk);
      #1 `CHK(xfer_grant, 7'h02)
      `CHK(xfer_grant, exp_grant(xfer_req))
      @(posedge ref_clk);
      xfer_req <= '0;
      // events against clears
      for (int k = 0; k < 40; k++) begin
         ev(NUM_CH'($random(seed) & $random(seed)), NUM_CH'($random(seed) & $random(seed)),
            NUM_CH'($random(seed) & $random(seed)));
         wr(OFS_FLAG, 32'hffffffff);
         rd(OFS_FLAG, {4'h0, flg_m});
         `CHK(chan_irq, exp_irq())
         d = (k % 8 == 7) ? 32'hffffffff : $random(seed) & $random(seed);
         wr(OFS_CLEAR, d);
         rd(OFS_FLAG, {4'h0, flg_m});
         rd(OFS_CLEAR, 32'h0);
         `CHK(chan_irq, exp_irq())
      end
      // event and clear in one cycle: the event wins
      @(posedge ref_clk);
      bus_addr <= OFS_CLEAR;
      bus_wdata <= 32'h0fffffff;
      bus_wr <= 1'b1;
      ev_fault <= 7'h01;
      @(posedge ref_clk);
      bus_wr <= 1'b0;
      ev_fault <= '0;
      flg_m = 28'h0000009;
      rd(OFS_FLAG, {4'h0, flg_m});
      // reset in mid-run returns every register to zero
      @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      flg_m = '0;
      foreach (ctl_m[c]) ctl_m[c] = CTL_RESET;
      @(posedge ref_clk);
      #1 chk_ports();
      `CHK(chan_irq, 7'h00)
      `CHK(xfer_grant, 7'h00)
      rd(OFS_FLAG, 32'h0);
      rd(ca(6), 32'h0);
      conclude();
   end

   initial begin
      repeat (100000) @(posedge ref_clk);
      n_fail++;
      conclude();
   end
endmodule : tb
